// file: logic/oas_pkg.sv
// Shared constants and types for the octal converter readout block.
package oas_pkg;

    localparam int OAS_CHANNELS    = 8;
    localparam int OAS_RESULT_BITS = 16;
    localparam int OAS_FRAME_BITS  = OAS_CHANNELS * OAS_RESULT_BITS;
    localparam int OAS_LVDS_LANES  = 4;

    // Register byte offsets.
    localparam logic [11:0] OAS_CTRL_OFS   = 12'h000;
    localparam logic [11:0] OAS_STATUS_OFS = 12'h004;
    localparam logic [11:0] OAS_COUNT_OFS  = 12'h008;

    // Control register fields and reset values.
    localparam int   OAS_CTRL_ECHO_EN_BIT = 0;
    localparam int   OAS_CTRL_OUT_EN_BIT  = 1;
    localparam logic OAS_CTRL_ECHO_EN_RST = 1'b1;
    localparam logic OAS_CTRL_OUT_EN_RST  = 1'b1;

    // Status register fields.
    localparam int OAS_STAT_PSTATE_LSB = 0;
    localparam int OAS_STAT_LVDS_BIT   = 3;
    localparam int OAS_STAT_DDR_BIT    = 4;
    localparam int OAS_STAT_ACTIVE_BIT = 5;
    localparam int OAS_STAT_INDEX_LSB  = 8;

    // Power-sequence pulse counts.
    localparam logic [2:0] OAS_NAP_PULSES   = 3'h2;
    localparam logic [2:0] OAS_SLEEP_PULSES = 3'h4;
    localparam logic [2:0] OAS_WAKE_PULSES  = 3'h5;

    typedef enum logic [2:0] {
        OAS_OPER  = 3'h1,
        OAS_NAP   = 3'h2,
        OAS_SLEEP = 3'h4
    } oas_pstate_t;

    // Channel 1 result sits in element 0, the most significant end.
    typedef logic [0:OAS_CHANNELS-1][OAS_RESULT_BITS-1:0] oas_frame_t;

    typedef struct packed {
        logic convert_start_n;
        logic serial_clock;
        logic data_rate_select;
        logic io_standard_select;
    } oas_pins_t;

    typedef struct packed {
        logic [OAS_CHANNELS-1:0]   cmos_lane;
        logic [OAS_LVDS_LANES-1:0] lvds_lane;
        logic                      echo_clock_out;
    } oas_lanes_t;

endpackage : oas_pkg

// file: logic/oas_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module oas_sync
    import oas_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } oas_sync_st_t;

    oas_sync_st_t s_q;
    oas_sync_st_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;

endmodule : oas_sync

// file: logic/oas_lane_pick.sv
// Selects the current bit of one serial lane from the result frame.
`timescale 1ns/10ps
module oas_lane_pick
    import oas_pkg::*;
#(
    parameter int START_CH = 0
) (
    input  wire oas_frame_t frame,
    input  wire logic [6:0] idx,
    output logic            bit_out
);
    localparam logic [6:0] START_OFS = 7'(START_CH * OAS_RESULT_BITS);

    logic [OAS_FRAME_BITS-1:0] flat;
    logic [6:0]                pos;

    // The position wraps modulo the frame so the lane keeps circling the channels.
    assign flat    = frame;
    assign pos     = idx + START_OFS;
    assign bit_out = flat[7'h7F - pos];

endmodule : oas_lane_pick

// file: logic/oas_readout.sv
// Readout, power sequencing and register slave of the octal converter.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - two quiet start pulses enter nap
// - serial clock rise wakes from nap
// - two more quiet pulses enter sleep
// - CMOS: serial clock rise wakes from sleep
// - fifth start pulse wakes from sleep
// - serial clock between pulses keeps operating
// - endless pulses cycle oper, nap, sleep
// - results shift out MSB first
// - echo clock copies serial clock, aligned
// - SDR advances on each falling edge
// - DDR advances on both edges
// - rate select low SDR, high DDR
// - standard select picks CMOS or LVDS lanes
// - CMOS lane circles channels from its own
// - each lane starts with its own channel's MSB
// - LVDS lanes start at pairs 1,3,5,7
// - LVDS lanes circle from their own pair
// - start rise samples, fall starts readout
module oas_readout
    import oas_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        convert_start_n,
    input  wire logic        serial_clock,
    input  wire logic        data_rate_select,
    input  wire logic        io_standard_select,
    input  wire oas_frame_t  sample_data,
    output oas_lanes_t       lanes,
    output oas_pstate_t      power_state
);
    typedef struct packed {
        oas_pstate_t pstate;
        logic [2:0]  pulse_cnt;
        logic        sck_seen;
        logic        cnv_prev;
        logic        sck_prev;
        logic        active;
        logic [6:0]  idx;
        oas_frame_t  sample;
        oas_frame_t  frame;
        oas_lanes_t  lanes;
        logic        echo_en;
        logic        out_en;
        logic [15:0] conv_cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } oas_state_t;

    oas_state_t              s_q;
    oas_state_t              s_d;
    oas_pins_t               pins_raw;
    oas_pins_t               pins_s;
    logic [OAS_CHANNELS-1:0] lane_bit;
    logic                    cnv_rise;
    logic                    cnv_fall;
    logic                    sck_rise;
    logic                    sck_fall;
    logic                    sck_any;
    logic                    quiet;
    logic [2:0]              cnt_new;
    logic                    shift;
    logic                    apb_access;
    logic                    apb_hit;

    assign pins_raw.convert_start_n    = convert_start_n;
    assign pins_raw.serial_clock       = serial_clock;
    assign pins_raw.data_rate_select   = data_rate_select;
    assign pins_raw.io_standard_select = io_standard_select;

    oas_sync #(
        .WIDTH ($bits(oas_pins_t))
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // Lane k begins at channel k+1; LVDS lanes reuse CMOS lanes k = 0, 2, 4 and 6 (channels 1, 3, 5, 7).
    for (genvar k = 0; k < OAS_CHANNELS; k++) begin : g_lane
        oas_lane_pick #(
            .START_CH (k)
        ) u_pick (
            .frame   (s_q.frame),
            .idx     (s_q.idx),
            .bit_out (lane_bit[k])
        );
    end

    assign cnv_rise   = pins_s.convert_start_n & ~s_q.cnv_prev;
    assign cnv_fall   = ~pins_s.convert_start_n & s_q.cnv_prev;
    assign sck_rise   = pins_s.serial_clock & ~s_q.sck_prev;
    assign sck_fall   = ~pins_s.serial_clock & s_q.sck_prev;
    assign sck_any    = sck_rise | sck_fall;
    assign quiet      = ~s_q.sck_seen & ~sck_any;
    assign cnt_new    = quiet ? 3'(s_q.pulse_cnt + 3'h1) : 3'h1;
    assign shift      = pins_s.data_rate_select ? sck_any : sck_fall;
    assign apb_access = psel & penable & ~s_q.pready;
    assign apb_hit    = (paddr == OAS_CTRL_OFS) || (paddr == OAS_STATUS_OFS) || (paddr == OAS_COUNT_OFS);

    always_comb begin
        s_d          = s_q;
        s_d.cnv_prev = pins_s.convert_start_n;
        s_d.sck_prev = pins_s.serial_clock;

        // Serial clock activity marks the gap since the last start pulse; it wins over the clear.
        if (sck_any) begin
            s_d.sck_seen = 1'b1;
        end else if (cnv_rise) begin
            s_d.sck_seen = 1'b0;
        end
        if (cnv_rise) begin
            s_d.pulse_cnt = cnt_new;
        end

        case (s_q.pstate)
            OAS_OPER: begin
                if (cnv_rise && cnt_new == OAS_NAP_PULSES) begin
                    s_d.pstate = OAS_NAP;
                    s_d.active = 1'b0;
                end else if (cnv_rise) begin
                    s_d.sample = sample_data;
                end
            end
            OAS_NAP: begin
                if (sck_rise) begin
                    s_d.pstate    = OAS_OPER;
                    s_d.pulse_cnt = 3'h0;
                end else if (cnv_rise && cnt_new == OAS_SLEEP_PULSES) begin
                    s_d.pstate = OAS_SLEEP;
                end
            end
            OAS_SLEEP: begin
                if (sck_rise && !pins_s.io_standard_select) begin
                    s_d.pstate    = OAS_OPER;
                    s_d.pulse_cnt = 3'h0;
                end else if (cnv_rise && cnt_new == OAS_WAKE_PULSES) begin
                    s_d.pstate    = OAS_OPER;
                    s_d.pulse_cnt = 3'h1;
                end
            end
            default: begin
                s_d.pstate    = OAS_OPER;
                s_d.pulse_cnt = 3'h0;
            end
        endcase

        // Falling start edge loads the frame and presents each lane's first MSB.
        if (s_q.pstate == OAS_OPER && cnv_fall) begin
            s_d.frame    = s_q.sample;
            s_d.idx      = 7'h00;
            s_d.active   = 1'b1;
            s_d.conv_cnt = 16'(s_q.conv_cnt + 16'h0001);
        end else if (s_q.active && s_q.pstate == OAS_OPER && shift) begin
            s_d.idx = 7'(s_q.idx + 7'h01);
        end

        // Lanes follow the index one cycle late; the echo is delayed by the same amount.
        s_d.lanes = '0;
        if (s_q.active && s_q.pstate == OAS_OPER && s_q.out_en) begin
            if (!pins_s.io_standard_select) begin
                s_d.lanes.cmos_lane = lane_bit;
            end else begin
                for (int j = 0; j < OAS_LVDS_LANES; j++) begin
                    s_d.lanes.lvds_lane[j] = lane_bit[2 * j];
                end
            end
        end
        s_d.lanes.echo_clock_out = s_q.echo_en & s_q.sck_prev;

        // Register slave: one wait state, errors on unmapped addresses.
        s_d.pready  = apb_access;
        s_d.pslverr = apb_access & ~apb_hit;
        s_d.prdata  = 32'h0000_0000;
        if (apb_access && pwrite && paddr == OAS_CTRL_OFS) begin
            s_d.echo_en = pwdata[OAS_CTRL_ECHO_EN_BIT];
            s_d.out_en  = pwdata[OAS_CTRL_OUT_EN_BIT];
        end
        if (apb_access && !pwrite) begin
            if (paddr == OAS_CTRL_OFS) begin
                s_d.prdata[OAS_CTRL_ECHO_EN_BIT] = s_q.echo_en;
                s_d.prdata[OAS_CTRL_OUT_EN_BIT]  = s_q.out_en;
            end else if (paddr == OAS_STATUS_OFS) begin
                s_d.prdata[OAS_STAT_PSTATE_LSB +: 3] = s_q.pstate;
                s_d.prdata[OAS_STAT_LVDS_BIT]        = pins_s.io_standard_select;
                s_d.prdata[OAS_STAT_DDR_BIT]         = pins_s.data_rate_select;
                s_d.prdata[OAS_STAT_ACTIVE_BIT]      = s_q.active;
                s_d.prdata[OAS_STAT_INDEX_LSB +: 7]  = s_q.idx;
            end else if (paddr == OAS_COUNT_OFS) begin
                s_d.prdata[15:0] = s_q.conv_cnt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.pstate  <= OAS_OPER;
            s_q.echo_en <= OAS_CTRL_ECHO_EN_RST;
            s_q.out_en  <= OAS_CTRL_OUT_EN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata      = s_q.prdata;
    assign pready      = s_q.pready;
    assign pslverr     = s_q.pslverr;
    assign lanes       = s_q.lanes;
    assign power_state = s_q.pstate;

    property p_nap_entry;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_OPER && cnv_rise && quiet && s_q.pulse_cnt == 3'h1) |=> (s_q.pstate == OAS_NAP);
    endproperty
    a_nap_entry: assert property (p_nap_entry) else $error("nap not entered on second quiet pulse");

    property p_nap_wake;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_NAP && sck_rise) |=> (s_q.pstate == OAS_OPER && s_q.pulse_cnt == 3'h0);
    endproperty
    a_nap_wake: assert property (p_nap_wake) else $error("nap not left on serial clock rise");

    property p_sleep_entry;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_NAP && !sck_rise && cnv_rise && quiet && s_q.pulse_cnt == 3'h3)
            |=> (s_q.pstate == OAS_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered on fourth pulse");

    property p_sleep_wake_sck;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_SLEEP && sck_rise && !pins_s.io_standard_select) |=> (s_q.pstate == OAS_OPER);
    endproperty
    a_sleep_wake_sck: assert property (p_sleep_wake_sck) else $error("CMOS sleep not left on clock");

    property p_fifth_pulse;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_SLEEP && !sck_rise && cnv_rise && quiet && s_q.pulse_cnt == 3'h4)
            |=> (s_q.pstate == OAS_OPER && s_q.pulse_cnt == 3'h1);
    endproperty
    a_fifth_pulse: assert property (p_fifth_pulse) else $error("fifth pulse did not wake");

    property p_stay_oper;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_OPER && cnv_rise && (s_q.sck_seen || sck_any))
            |=> (s_q.pstate == OAS_OPER && s_q.pulse_cnt == 3'h1);
    endproperty
    a_stay_oper: assert property (p_stay_oper) else $error("active clock failed to hold operation");

    property p_msb_first;
        @(posedge pclk) disable iff (!presetn)
        (s_q.pstate == OAS_OPER && cnv_fall && s_q.out_en && !pins_s.io_standard_select)
            |=> (s_q.idx == 7'h00 && s_q.active)
            ##1 (lanes.cmos_lane[0] == $past(s_q.frame[0][15]) && lanes.cmos_lane[4] == $past(s_q.frame[4][15]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("lanes did not start with the MSB");

    property p_sdr_shift;
        @(posedge pclk) disable iff (!presetn)
        (s_q.active && s_q.pstate == OAS_OPER && !pins_s.data_rate_select && !cnv_fall && !cnv_rise)
            |=> (s_q.idx == 7'($past(s_q.idx) + 7'($past(sck_fall))));
    endproperty
    a_sdr_shift: assert property (p_sdr_shift) else $error("SDR index did not follow falling edges");

    property p_ddr_shift;
        @(posedge pclk) disable iff (!presetn)
        (s_q.active && s_q.pstate == OAS_OPER && pins_s.data_rate_select && sck_rise && !cnv_fall && !cnv_rise)
            |=> (s_q.idx == 7'($past(s_q.idx) + 7'h01));
    endproperty
    a_ddr_shift: assert property (p_ddr_shift) else $error("DDR index did not advance on rise");

    property p_echo;
        @(posedge pclk) disable iff (!presetn)
        (s_q.echo_en && $past(s_q.echo_en)) |-> (lanes.echo_clock_out == $past(pins_s.serial_clock, 2));
    endproperty
    a_echo: assert property (p_echo) else $error("echo clock does not track serial clock");

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> (pready ##1 !pready);
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("register access not answered in one cycle");

endmodule : oas_readout

// file: testbench/oas_host_model.sv
// Host controller model: drives the start and serial clock pins and captures the lanes.
`timescale 1ns/10ps
module oas_host_model
    import oas_pkg::*;
#(
    parameter int WAKE_WAIT_CYC = 250000
) (
    input  wire logic       pclk,
    input  wire oas_lanes_t lanes,
    input  wire logic       data_rate_select,
    output logic            convert_start_n,
    output logic            serial_clock
);
    logic [127:0] cap [12];
    int           cap_n;
    logic         lane_seen;
    logic         echo_q;
    oas_lanes_t   lanes_q;

    task automatic clear();
        cap_n     = 0;
        lane_seen = 1'h0;
        for (int k = 0; k < 12; k++) begin
            cap[k] = 128'h0;
        end
    endtask : clear

    // Each level is held well beyond the synchroniser depth.
    task automatic cnv_pulse();
        @(posedge pclk) convert_start_n <= 1'h1;
        repeat (4) @(posedge pclk);
        convert_start_n <= 1'h0;
        repeat (4) @(posedge pclk);
    endtask : cnv_pulse

    // The serial clock runs only here and stands still between calls.
    task automatic sck_cycles(input int n);
        repeat (n) begin
            @(posedge pclk) serial_clock <= 1'h1;
            repeat (4) @(posedge pclk);
            serial_clock <= 1'h0;
            repeat (3) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask : sck_cycles

    task automatic wake_settle();
        repeat (WAKE_WAIT_CYC) @(posedge pclk);
    endtask : wake_settle

    initial begin
        convert_start_n = 1'h0;
        serial_clock    = 1'h0;
        echo_q          = 1'h0;
        lanes_q         = '0;
        clear();
    end

    // Data is taken one cycle delayed on the echo edges that the rate calls for.
    always @(posedge pclk) begin
        if (lanes.echo_clock_out != echo_q && (data_rate_select || lanes.echo_clock_out)) begin
            for (int k = 0; k < 8; k++) begin
                cap[k] = {cap[k][126:0], lanes_q.cmos_lane[k]};
            end
            for (int m = 0; m < 4; m++) begin
                cap[8+m] = {cap[8+m][126:0], lanes_q.lvds_lane[m]};
            end
            cap_n++;
        end
        lane_seen = lane_seen | (|lanes.cmos_lane) | (|lanes.lvds_lane);
        echo_q    = lanes.echo_clock_out;
        lanes_q   = lanes;
    end
endmodule : oas_host_model

// file: testbench/tb_oas_readout.sv
// Self-checking testbench for the octal converter readout block.
`timescale 1ns/10ps
module tb_oas_readout
    import oas_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        convert_start_n;
    logic        serial_clock;
    logic        data_rate_select;
    logic        io_standard_select;
    oas_frame_t  sample_data;
    oas_lanes_t  lanes;
    oas_pstate_t power_state;
    int          fail_count;
    int          n_compared;

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    oas_readout oas_readout_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convert_start_n(convert_start_n), .serial_clock(serial_clock),
        .data_rate_select(data_rate_select), .io_standard_select(io_standard_select),
        .sample_data(sample_data), .lanes(lanes), .power_state(power_state)
    );

    // The settling wait after sleep is shortened; the block does not enforce it.
    oas_host_model #(.WAKE_WAIT_CYC(16)) oas_host_model_inst (
        .pclk(pclk), .lanes(lanes), .data_rate_select(data_rate_select),
        .convert_start_n(convert_start_n), .serial_clock(serial_clock)
    );

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check

    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic do_reset();
        @(posedge pclk) presetn <= 1'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
    endtask : do_reset

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       input logic [31:0] exp, input logic exp_err);
        int n;
        @(posedge pclk);
        psel   <= 1'h1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        psel    <= 1'h0;
        penable <= 1'h0;
        check("pready", 1'h1, pready);
        check("pslverr", exp_err, pslverr);
        if (!w) begin
            check("prdata", exp, prdata);
        end
    endtask : apb

    function automatic logic [127:0] rot(input oas_frame_t f, input int c);
        logic [127:0] r;
        for (int i = 0; i < 8; i++) begin
            r[127-16*i -: 16] = f[(c+i)%8];
        end
        return r;
    endfunction : rot

    task automatic t_regs();
        apb(OAS_CTRL_OFS, 1'h0, 32'h0, {30'h0, OAS_CTRL_OUT_EN_RST, OAS_CTRL_ECHO_EN_RST}, 1'h0);
        apb(OAS_STATUS_OFS, 1'h0, 32'h0, {29'h0, OAS_OPER}, 1'h0);
        apb(OAS_COUNT_OFS, 1'h0, 32'h0, 32'h0, 1'h0);
        apb(OAS_STATUS_OFS, 1'h1, 32'hFFFF_FFFF, 32'h0, 1'h0);
        apb(OAS_STATUS_OFS, 1'h0, 32'h0, {29'h0, OAS_OPER}, 1'h0);
        apb(12'h00C, 1'h1, 32'h0000_0003, 32'h0, 1'h1);
        apb(12'h00C, 1'h0, 32'h0, 32'h0, 1'h1);
    endtask : t_regs

    // Sample input changes after the start pulse must not reach the lanes.
    task automatic t_readout(input logic std, input logic ddr, input logic [15:0] seed);
        oas_frame_t f;
        for (int i = 0; i < 8; i++) begin
            f[i] = seed ^ 16'(i * 16'h2468);
        end
        @(posedge pclk);
        io_standard_select <= std;
        data_rate_select   <= ddr;
        sample_data        <= f;
        repeat (6) @(posedge pclk);
        oas_host_model_inst.clear();
        oas_host_model_inst.cnv_pulse();
        sample_data <= ~f;
        oas_host_model_inst.sck_cycles(ddr ? 64 : 128);
        check("echo bits", 128'd128, oas_host_model_inst.cap_n);
        apb(OAS_STATUS_OFS, 1'h0, 32'h0, {26'h0, 1'h1, ddr, std, 3'h1}, 1'h0);
        for (int k = 0; k < 8; k++) begin
            check("cmos lane", std ? 128'h0 : rot(f, k), oas_host_model_inst.cap[k]);
        end
        for (int m = 0; m < 4; m++) begin
            check("lvds lane", std ? rot(f, 2*m) : 128'h0, oas_host_model_inst.cap[8+m]);
        end
    endtask : t_readout

    task automatic t_enables();
        apb(OAS_CTRL_OFS, 1'h1, 32'h0, 32'h0, 1'h0);
        apb(OAS_CTRL_OFS, 1'h0, 32'h0, 32'h0, 1'h0);
        oas_host_model_inst.clear();
        oas_host_model_inst.cnv_pulse();
        oas_host_model_inst.sck_cycles(16);
        check("echo while disabled", 128'h0, oas_host_model_inst.cap_n);
        check("lanes while disabled", 128'h0, oas_host_model_inst.lane_seen);
        apb(OAS_CTRL_OFS, 1'h1, 32'h0000_0003, 32'h0, 1'h0);
    endtask : t_enables

    task automatic expect_state(input oas_pstate_t s);
        repeat (4) @(posedge pclk);
        check("power state", s, power_state);
        if (s != OAS_OPER) begin
            check("idle lanes", 128'h0, {lanes.cmos_lane, lanes.lvds_lane});
        end
    endtask : expect_state

    task automatic t_power(input logic std);
        @(posedge pclk) io_standard_select <= std;
        repeat (6) @(posedge pclk);
        repeat (3) begin
            oas_host_model_inst.cnv_pulse();
            oas_host_model_inst.sck_cycles(1);
        end
        expect_state(OAS_OPER);
        repeat (2) oas_host_model_inst.cnv_pulse();
        expect_state(OAS_NAP);
        oas_host_model_inst.sck_cycles(1);
        expect_state(OAS_OPER);
        repeat (4) oas_host_model_inst.cnv_pulse();
        expect_state(OAS_SLEEP);
        oas_host_model_inst.cnv_pulse();
        expect_state(OAS_OPER);
        oas_host_model_inst.wake_settle();
        oas_host_model_inst.cnv_pulse();
        expect_state(OAS_NAP);
        repeat (2) oas_host_model_inst.cnv_pulse();
        expect_state(OAS_SLEEP);
        oas_host_model_inst.sck_cycles(1);
        expect_state(std ? OAS_SLEEP : OAS_OPER);
        do_reset();
    endtask : t_power

    initial begin
        presetn            = 1'h0;
        psel               = 1'h0;
        penable            = 1'h0;
        pwrite             = 1'h0;
        paddr              = 12'h0;
        pwdata             = 32'h0;
        data_rate_select   = 1'h0;
        io_standard_select = 1'h0;
        sample_data        = '0;
        fail_count         = 0;
        n_compared         = 0;
        do_reset();
        t_regs();
        t_readout(1'h0, 1'h0, 16'hA5C3);
        t_readout(1'h0, 1'h1, 16'h3C96);
        t_readout(1'h1, 1'h0, 16'hF00D);
        t_readout(1'h1, 1'h1, 16'h8421);
        apb(OAS_COUNT_OFS, 1'h0, 32'h0, 32'h0000_0004, 1'h0);
        t_enables();
        t_power(1'h0);
        t_power(1'h1);
        complete_run();
    end

    initial begin
        #1_000_000;
        fail_count++;
        complete_run();
    end
endmodule : tb_oas_readout
